// File: rtl/dspt_async_slot.sv
`include "dspt_params.svh"
`default_nettype none
module dspt_async_slot (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire dspt_pkg::dspt_byte_t wdata_i,
  input wire logic async_i,
  input wire logic edge_i,
  output dspt_pkg::dspt_byte_t dest_o,
  output logic load_o,
  output logic busy_o
);
  import dspt_pkg::*;

  dspt_byte_t temp_r; // Temporary holding register
  logic [1:0] edges_r; // Oscillator edges seen since the write
  logic xfer_w; // Transfer completes this cycle

  // Sync mode moves on the next cycle; async waits for the second edge
  assign xfer_w = busy_o && !wr_i && (!async_i || (edge_i && edges_r == `DSPT_ASYNC_EDGES - 2'h1));

  // Temporary register, edge count and busy flag; a new write wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      temp_r <= `DSPT_RST_BYTE;
      edges_r <= 2'h0;
      busy_o <= 1'b0;
    end else if (wr_i) begin
      temp_r <= wdata_i; // RULE11
      edges_r <= 2'h0;
      busy_o <= 1'b1; // RULE27
    end else if (xfer_w) begin
      busy_o <= 1'b0; // RULE12
    end else if (busy_o && edge_i) begin
      edges_r <= edges_r + 2'h1;
    end
  end

  // Destination and its one-cycle load strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dest_o <= `DSPT_RST_BYTE;
      load_o <= 1'b0;
    end else begin
      load_o <= xfer_w;
      if (xfer_w) begin
        dest_o <= temp_r; // RULE11
      end
    end
  end
endmodule
`default_nettype wire

// File: rtl/dspt_params.svh
// Contract
// RULE1: Waveform mode 0x1 or 0x5 selects dual-slope
// RULE2: Top is 0xFF, or compare A value
// RULE3: Count up to top, hold once, down
// RULE4: Mode two clears up, sets down; three inverts
// RULE5: Overflow flag set whenever counter reaches bottom
// RULE6: Compare bottom gives low, max gives high
// RULE7: Leaving max, bottom acts as up-match
// RULE8: Missed up-match still transitions at bottom
// RULE9: Period is 510 prescaled ticks, selectable prescale
// RULE10: Software sets pin direction to output
// RULE11: Async writes land after two oscillator edges
// RULE12: Busy flag per register, clears on transfer
// RULE13: Software waits for busy before rewriting
// RULE14: No compare match while write pending
// RULE15: Software follows safe clock-switch sequence
// RULE16: Wake request starts on next timer cycle
// RULE17: Count read via holding register, refreshed per edge
// RULE18: After wake, old count until next edge
// RULE19: Async flags arrive three cycles plus one tick
// RULE20: Output pin changes on timer tick directly
// RULE21: Software waits busy clear before sleeping again
// RULE22: Software treats registers invalid after deep sleep
// RULE23: Async select switches clock to oscillator input
// RULE24: Prescale 1..1024 or stop, with reset bit
// RULE25: Compare equal top: action done at top
// RULE26: Counter advances only on prescaled tick
// RULE27: Busy set on write, cleared on transfer
`ifndef DSPT_PARAMS_SVH
`define DSPT_PARAMS_SVH

// Register byte offsets
`define DSPT_OFF_CTRL_A 8'h00
`define DSPT_OFF_CTRL_B 8'h04
`define DSPT_OFF_COUNT 8'h08
`define DSPT_OFF_CMP_A 8'h0c
`define DSPT_OFF_CMP_B 8'h10
`define DSPT_OFF_ASYNC 8'h14
`define DSPT_OFF_FLAGS 8'h18
`define DSPT_OFF_IRQ_EN 8'h1c
`define DSPT_OFF_PSC_RST 8'h20

// Slot indices of the buffered registers
`define DSPT_SLOT_CTRL_A 0
`define DSPT_SLOT_CTRL_B 1
`define DSPT_SLOT_COUNT 2
`define DSPT_SLOT_CMP_A 3
`define DSPT_SLOT_CMP_B 4
`define DSPT_NUM_SLOTS 5

// Field positions
`define DSPT_ASYNC_SEL_BIT 5
`define DSPT_WAVEFORM_MODE_FIELD_BIT 3
`define DSPT_FLAG_OVF 0
`define DSPT_FLAG_CMP_A 1
`define DSPT_FLAG_CMP_B 2

// Reset and mode values
`define DSPT_RST_BYTE 8'h00
`define DSPT_MODE_DUAL_FIXED 3'h1
`define DSPT_MODE_DUAL_CMPA 3'h5
`define DSPT_TOP_FIXED 8'hff
`define DSPT_BOTTOM 8'h00

// Prescaler masks (divide by mask + 1)
`define DSPT_MASK_1 10'h000
`define DSPT_MASK_8 10'h007
`define DSPT_MASK_32 10'h01f
`define DSPT_MASK_64 10'h03f
`define DSPT_MASK_128 10'h07f
`define DSPT_MASK_256 10'h0ff
`define DSPT_MASK_1024 10'h3ff

// Timing counts
`define DSPT_ASYNC_EDGES 2'h2
`define DSPT_FLAG_SYNC_CYC 3

`endif

// File: rtl/dspt_pkg.sv
`default_nettype none
package dspt_pkg;
  // Bus data word
  typedef logic [31:0] dspt_word_t;
  // Timer register byte
  typedef logic [7:0] dspt_byte_t;
  // Prescaler selection
  typedef enum logic [2:0] {
    DSPT_CS_STOP = 3'b000,
    DSPT_CS_DIV1 = 3'b001,
    DSPT_CS_DIV8 = 3'b010,
    DSPT_CS_DIV32 = 3'b011,
    DSPT_CS_DIV64 = 3'b100,
    DSPT_CS_DIV128 = 3'b101,
    DSPT_CS_DIV256 = 3'b110,
    DSPT_CS_DIV1024 = 3'b111
  } dspt_clksel_t;
endpackage
`default_nettype wire

// File: rtl/dspt_prescaler.sv
`include "dspt_params.svh"
`default_nettype none
module dspt_prescaler (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic src_tick_i,
  input wire dspt_pkg::dspt_clksel_t sel_i,
  input wire logic clr_i,
  output logic tick_o
);
  import dspt_pkg::*;

  logic [9:0] div_r; // Shared divider chain
  logic [9:0] mask_w; // Low bits that must all be one

  // Divider advances on source ticks; reset bit restarts it
  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      div_r <= 10'h000; // RULE24
    end else if (src_tick_i) begin
      div_r <= div_r + 10'h001;
    end
  end

  // Select the division mask
  always_comb begin
    case (sel_i)
      DSPT_CS_DIV1: mask_w = `DSPT_MASK_1;
      DSPT_CS_DIV8: mask_w = `DSPT_MASK_8;
      DSPT_CS_DIV32: mask_w = `DSPT_MASK_32;
      DSPT_CS_DIV64: mask_w = `DSPT_MASK_64;
      DSPT_CS_DIV128: mask_w = `DSPT_MASK_128;
      DSPT_CS_DIV256: mask_w = `DSPT_MASK_256;
      DSPT_CS_DIV1024: mask_w = `DSPT_MASK_1024;
      default: mask_w = `DSPT_MASK_1;
    endcase
  end

  // Stop selection never ticks
  assign tick_o = src_tick_i && (sel_i != DSPT_CS_STOP) && ((div_r & mask_w) == mask_w); // RULE24
endmodule
`default_nettype wire

// File: rtl/dspt_timer_top.sv
// The implementer's own choices: the register offsets and register access over Wishbone.
`include "dspt_params.svh"
`default_nettype none
module dspt_timer_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire dspt_pkg::dspt_word_t wb_dat_i,
  output logic wb_ack_o,
  output dspt_pkg::dspt_word_t wb_dat_o,
  input wire logic async_osc_input_i,
  output logic compare_out_pin_a_o,
  output logic compare_out_pin_b_o,
  output logic wake_request_o
);
  import dspt_pkg::*;

  // Bus decode
  logic req_w; // New request not yet answered
  logic wr_go_w; // Write with the data byte lane enabled
  logic [`DSPT_NUM_SLOTS-1:0] slot_wr_w; // Writes into buffered registers
  logic flags_wr_w; // Flag clear write
  logic psc_clr_w; // Prescaler reset strobe

  // Buffered registers
  dspt_byte_t slot_dest_w [`DSPT_NUM_SLOTS]; // Destination values
  logic [`DSPT_NUM_SLOTS-1:0] slot_load_w; // Transfer strobes
  logic [`DSPT_NUM_SLOTS-1:0] slot_busy_w; // Update-busy flags

  // Control state
  logic async_select_bit_r; // Oscillator pin clocks the timer
  logic [2:0] irq_en_r; // Overflow and compare enables
  logic [2:0] flag_r; // Overflow and compare flags
  logic osc_q_r; // Previous oscillator level
  logic osc_rise_w; // Oscillator rising edge
  logic src_tick_w; // Undivided timer clock enable
  logic timer_tick_enable; // Prescaled timer clock enable

  // Counter state
  dspt_byte_t count_value_r; // Running counter
  dspt_byte_t count_hold_r; // Bus-side copy of the counter
  logic count_up_r; // Counting direction
  logic [2:0] waveform_mode_field; // Mode select
  logic dual_w; // Dual-slope mode active
  dspt_byte_t top_w; // Current top
  logic at_top_w; // Counter sits at or beyond top on the up slope
  logic at_bottom_w; // Counter sits at bottom

  // Channel state
  dspt_byte_t compare_value_chan [2]; // Compare values, A then B
  logic [1:0] compare_output_mode_field [2]; // Output modes, A then B
  logic [1:0] hit_w; // Compare matches this tick
  logic [1:0] pin_r; // Output pin levels
  logic [1:0] was_max_r; // Compare value sat at top last turn
  logic [1:0] missed_r; // Up-slope match was skipped

  // Flag events and their synchroniser pipe
  logic [2:0] ev_w; // Raw events this tick
  logic [2:0] ev_d1_r; // Pipe stage one
  logic [2:0] ev_d2_r; // Pipe stage two
  logic [2:0] ev_d3_r; // Pipe stage three
  logic [2:0] set_w; // Events that set flags now
  logic wake_pend_r; // Enabled event awaiting a timer cycle

  assign req_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_go_w = req_w && wb_we_i && wb_sel_i[0];
  assign flags_wr_w = wr_go_w && (wb_adr_i == `DSPT_OFF_FLAGS);
  assign psc_clr_w = wr_go_w && (wb_adr_i == `DSPT_OFF_PSC_RST) && wb_dat_i[0];

  // Decode writes to the buffered registers
  always_comb begin
    slot_wr_w = '0;
    slot_wr_w[`DSPT_SLOT_CTRL_A] = wr_go_w && (wb_adr_i == `DSPT_OFF_CTRL_A);
    slot_wr_w[`DSPT_SLOT_CTRL_B] = wr_go_w && (wb_adr_i == `DSPT_OFF_CTRL_B);
    slot_wr_w[`DSPT_SLOT_COUNT] = wr_go_w && (wb_adr_i == `DSPT_OFF_COUNT);
    slot_wr_w[`DSPT_SLOT_CMP_A] = wr_go_w && (wb_adr_i == `DSPT_OFF_CMP_A);
    slot_wr_w[`DSPT_SLOT_CMP_B] = wr_go_w && (wb_adr_i == `DSPT_OFF_CMP_B);
  end

  // One temporary register per buffered register, so writes never disturb each other
  genvar gi;
  generate
    for (gi = 0; gi < `DSPT_NUM_SLOTS; gi = gi + 1) begin : g_slot
      dspt_async_slot u_slot (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_i(slot_wr_w[gi]),
        .wdata_i(wb_dat_i[7:0]),
        .async_i(async_select_bit_r),
        .edge_i(osc_rise_w),
        .dest_o(slot_dest_w[gi]),
        .load_o(slot_load_w[gi]),
        .busy_o(slot_busy_w[gi])
      );
    end
  endgenerate

  // Field extraction from the control registers
  assign waveform_mode_field = {slot_dest_w[`DSPT_SLOT_CTRL_B][`DSPT_WAVEFORM_MODE_FIELD_BIT],
                                slot_dest_w[`DSPT_SLOT_CTRL_A][1:0]};
  assign compare_output_mode_field[0] = slot_dest_w[`DSPT_SLOT_CTRL_A][7:6];
  assign compare_output_mode_field[1] = slot_dest_w[`DSPT_SLOT_CTRL_A][5:4];
  assign compare_value_chan[0] = slot_dest_w[`DSPT_SLOT_CMP_A];
  assign compare_value_chan[1] = slot_dest_w[`DSPT_SLOT_CMP_B];
  assign dual_w = (waveform_mode_field == `DSPT_MODE_DUAL_FIXED) ||
                  (waveform_mode_field == `DSPT_MODE_DUAL_CMPA); // RULE1
  assign top_w = (waveform_mode_field == `DSPT_MODE_DUAL_CMPA) ?
                 compare_value_chan[0] : `DSPT_TOP_FIXED; // RULE2
  assign at_top_w = count_up_r && (count_value_r >= top_w);
  assign at_bottom_w = (count_value_r == `DSPT_BOTTOM);

  // Oscillator input is sampled on clk; its rising edge is the async source tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_q_r <= 1'b0;
    end else begin
      osc_q_r <= async_osc_input_i;
    end
  end
  assign osc_rise_w = async_osc_input_i && !osc_q_r;
  assign src_tick_w = async_select_bit_r ? osc_rise_w : 1'b1; // RULE23

  dspt_prescaler u_psc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .src_tick_i(src_tick_w),
    .sel_i(dspt_clksel_t'(slot_dest_w[`DSPT_SLOT_CTRL_B][2:0])),
    .clr_i(psc_clr_w),
    .tick_o(timer_tick_enable)
  );

  // Clock source select and interrupt enables are written directly
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      async_select_bit_r <= 1'b0;
      irq_en_r <= 3'h0;
    end else if (wr_go_w && wb_adr_i == `DSPT_OFF_ASYNC) begin
      async_select_bit_r <= wb_dat_i[`DSPT_ASYNC_SEL_BIT]; // RULE23
    end else if (wr_go_w && wb_adr_i == `DSPT_OFF_IRQ_EN) begin
      irq_en_r <= wb_dat_i[2:0];
    end
  end

  // Counter: a completed write loads it, otherwise it moves only on timer ticks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_value_r <= `DSPT_BOTTOM;
      count_up_r <= 1'b1;
    end else if (slot_load_w[`DSPT_SLOT_COUNT]) begin
      count_value_r <= slot_dest_w[`DSPT_SLOT_COUNT];
    end else if (timer_tick_enable) begin // RULE26
      if (!dual_w) begin
        // Other modes just run upward
        count_value_r <= count_value_r + 8'h01;
        count_up_r <= 1'b1;
      end else if (at_top_w) begin
        // Top has been held for one tick; turn round
        count_up_r <= 1'b0; // RULE3
        count_value_r <= (top_w == `DSPT_BOTTOM) ? `DSPT_BOTTOM : count_value_r - 8'h01;
      end else if (count_up_r) begin
        count_value_r <= count_value_r + 8'h01; // RULE9
      end else if (at_bottom_w) begin
        count_up_r <= 1'b1;
        count_value_r <= (top_w == `DSPT_BOTTOM) ? `DSPT_BOTTOM : 8'h01; // RULE9
      end else begin
        count_value_r <= count_value_r - 8'h01;
      end
    end
  end

  // Each channel's match is blocked while a counter write or its own compare write is in flight
  always_comb begin
    hit_w[0] = timer_tick_enable && (count_value_r == compare_value_chan[0]) &&
               !slot_busy_w[`DSPT_SLOT_COUNT] && !slot_busy_w[`DSPT_SLOT_CMP_A]; // RULE14
    hit_w[1] = timer_tick_enable && (count_value_r == compare_value_chan[1]) &&
               !slot_busy_w[`DSPT_SLOT_COUNT] && !slot_busy_w[`DSPT_SLOT_CMP_B]; // RULE14
  end

  // Output waveform per channel, updated straight on the timer tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_r <= 2'b00;
      was_max_r <= 2'b00;
      missed_r <= 2'b00;
    end else begin
      for (int ch = 0; ch < 2; ch++) begin
        if (!dual_w || !compare_output_mode_field[ch][1]) begin
          // Disconnected or not a dual-slope mode
          pin_r[ch] <= 1'b0;
          missed_r[ch] <= 1'b0;
        end else if (slot_load_w[`DSPT_SLOT_COUNT]) begin
          // Starting above the compare value skips the up-slope match
          missed_r[ch] <= slot_dest_w[`DSPT_SLOT_COUNT] > compare_value_chan[ch]; // RULE8
        end else if (timer_tick_enable) begin // RULE20
          if (hit_w[ch] && at_top_w) begin
            // Match at top acts as the down-slope action
            pin_r[ch] <= !compare_output_mode_field[ch][0]; // RULE25
          end else if (hit_w[ch] && at_bottom_w) begin
            // Bottom is the start of the up slope
            pin_r[ch] <= compare_output_mode_field[ch][0]; // RULE6
          end else if (hit_w[ch]) begin
            // Mode two clears going up and sets going down; mode three inverts
            pin_r[ch] <= count_up_r ? compare_output_mode_field[ch][0]
                                    : !compare_output_mode_field[ch][0]; // RULE4
          end else if (at_bottom_w && !count_up_r &&
                       ((was_max_r[ch] && compare_value_chan[ch] != top_w) || missed_r[ch])) begin
            // Keep the waveform symmetric around bottom without a match
            pin_r[ch] <= compare_output_mode_field[ch][0]; // RULE7
          end
          if (at_top_w) begin
            was_max_r[ch] <= (compare_value_chan[ch] == top_w);
          end
          if (at_bottom_w) begin
            missed_r[ch] <= 1'b0; // RULE8
          end
        end
      end
    end
  end
  assign compare_out_pin_a_o = pin_r[0];
  assign compare_out_pin_b_o = pin_r[1];

  // Raw flag events of this tick
  always_comb begin
    ev_w = 3'h0;
    ev_w[`DSPT_FLAG_OVF] = timer_tick_enable &&
                           (dual_w ? at_bottom_w : count_value_r == `DSPT_TOP_FIXED); // RULE5
    ev_w[`DSPT_FLAG_CMP_A] = hit_w[0];
    ev_w[`DSPT_FLAG_CMP_B] = hit_w[1];
  end

  // Async flags cross through a three-cycle pipe; sync flags set at once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_d1_r <= 3'h0;
      ev_d2_r <= 3'h0;
      ev_d3_r <= 3'h0;
    end else begin
      ev_d1_r <= async_select_bit_r ? ev_w : 3'h0; // RULE19
      ev_d2_r <= ev_d1_r;
      ev_d3_r <= ev_d2_r;
    end
  end
  assign set_w = async_select_bit_r ? ev_d3_r : (ev_w | ev_d3_r); // RULE19

  // Flags: write one to clear, a same-cycle event wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_r <= 3'h0;
    end else begin
      flag_r <= (flag_r & ~(flags_wr_w ? wb_dat_i[2:0] : 3'h0)) | set_w; // RULE5
    end
  end

  // Wake request goes out on the timer cycle after an enabled event
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_pend_r <= 1'b0;
      wake_request_o <= 1'b0;
    end else begin
      wake_request_o <= wake_pend_r && src_tick_w; // RULE16
      if ((ev_w & irq_en_r) != 3'h0) begin
        wake_pend_r <= 1'b1;
      end else if (src_tick_w) begin
        wake_pend_r <= 1'b0;
      end
    end
  end

  // Counter copy for the bus, refreshed per oscillator edge in async mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_hold_r <= `DSPT_BOTTOM;
    end else if (!async_select_bit_r || osc_rise_w) begin
      count_hold_r <= count_value_r; // RULE17 RULE18
    end
  end

  // Bus answer: ack one cycle after the request, unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= req_w;
      wb_dat_o <= '0;
      if (req_w && !wb_we_i) begin
        case (wb_adr_i)
          `DSPT_OFF_CTRL_A: wb_dat_o[7:0] <= slot_dest_w[`DSPT_SLOT_CTRL_A];
          `DSPT_OFF_CTRL_B: wb_dat_o[7:0] <= slot_dest_w[`DSPT_SLOT_CTRL_B];
          `DSPT_OFF_COUNT: wb_dat_o[7:0] <= count_hold_r; // RULE17
          `DSPT_OFF_CMP_A: wb_dat_o[7:0] <= slot_dest_w[`DSPT_SLOT_CMP_A];
          `DSPT_OFF_CMP_B: wb_dat_o[7:0] <= slot_dest_w[`DSPT_SLOT_CMP_B];
          `DSPT_OFF_ASYNC: wb_dat_o[5:0] <= {async_select_bit_r, slot_busy_w}; // RULE12
          `DSPT_OFF_FLAGS: wb_dat_o[2:0] <= flag_r;
          `DSPT_OFF_IRQ_EN: wb_dat_o[2:0] <= irq_en_r;
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// File: verification/dspt_osc_model.sv
`default_nettype none
module dspt_osc_model (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic [7:0] half_i,
  input wire logic dir_i,
  input wire logic pin_a_i,
  output logic osc_o,
  output logic pad_a_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_r = 8'h00; // Half-period counter
  logic osc_r = 1'b0; // Crystal level, low while stopped
  // Free-running crystal, several clk cycles per level
  always @(posedge clk_i) begin
    if (!run_i) begin
      cnt_r <= 8'h00;
      osc_r <= 1'b0;
    end else if (cnt_r == half_i - 8'h01) begin
      cnt_r <= 8'h00;
      osc_r <= ~osc_r;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
  assign osc_o = osc_r;
  // Pad pulled up; waveform shows only when the port drives it
  assign pad_a_o = dir_i ? pin_a_i : 1'b1;
endmodule
`default_nettype wire

// File: verification/dspt_timer_checker.sv
`include "dspt_params.svh"
`default_nettype none
module dspt_timer_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire dspt_pkg::dspt_word_t wb_dat_i,
  input wire logic wb_ack_o,
  input wire dspt_pkg::dspt_word_t wb_dat_o,
  input wire logic async_osc_input_i,
  input wire logic compare_out_pin_a_o,
  input wire logic compare_out_pin_b_o,
  input wire logic wake_request_o
);
  import dspt_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic take, wr, rd_async, rise, dual, idle_ok; // Decoded conditions of this edge
  dspt_byte_t ctrl_a_r, ctrl_b_r, irq_en_r;
  logic async_r, osc_d_r;
  logic [1:0] rises_r; // Rises since async count write, saturating
  logic [5:0] quiet_r; // Cycles since a buffered or async-select write, saturating
  logic [5:0] irq_off_r; // Cycles since enables went all zero
  assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = take & wb_we_i & wb_sel_i[0];
  assign rd_async = take & ~wb_we_i & (wb_adr_i == `DSPT_OFF_ASYNC) & async_r;
  assign rise = async_osc_input_i & ~osc_d_r;
  assign dual = ({ctrl_b_r[3], ctrl_a_r[1:0]} == `DSPT_MODE_DUAL_FIXED) ||
                ({ctrl_b_r[3], ctrl_a_r[1:0]} == `DSPT_MODE_DUAL_CMPA);
  assign idle_ok = (quiet_r == 6'h3f) && !async_r;
  // Shadow of what software wrote; margins cover the transfer lag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_a_r <= 8'h00;
      ctrl_b_r <= 8'h00;
      irq_en_r <= 8'h00;
      async_r <= 1'b0;
    end else if (wr) begin
      if (wb_adr_i == `DSPT_OFF_CTRL_A) ctrl_a_r <= wb_dat_i[7:0];
      if (wb_adr_i == `DSPT_OFF_CTRL_B) ctrl_b_r <= wb_dat_i[7:0];
      if (wb_adr_i == `DSPT_OFF_IRQ_EN) irq_en_r <= wb_dat_i[7:0];
      if (wb_adr_i == `DSPT_OFF_ASYNC) async_r <= wb_dat_i[`DSPT_ASYNC_SEL_BIT];
    end
  end
  // Settle, rise and wake-span counters
  always_ff @(posedge clk_i) begin
    osc_d_r <= async_osc_input_i;
    if (rst_i) begin
      rises_r <= 2'h3;
      quiet_r <= 6'h00;
      irq_off_r <= 6'h3f;
    end else begin
      if (wr && wb_adr_i == `DSPT_OFF_COUNT && async_r) rises_r <= 2'h0;
      else if (rise && rises_r != 2'h3) rises_r <= rises_r + 2'h1;
      if (wr && wb_adr_i <= `DSPT_OFF_ASYNC) quiet_r <= 6'h00;
      else if (quiet_r != 6'h3f) quiet_r <= quiet_r + 6'h01;
      if (irq_en_r != 8'h00) irq_off_r <= 6'h00;
      else if (irq_off_r != 6'h3f) irq_off_r <= irq_off_r + 6'h01;
    end
  end
  chk_ack_latency: assert property (take |=> wb_ack_o) else $error("ack late");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data not idle");
  chk_unmapped_zero: assert property (take && !wb_we_i && wb_adr_i > `DSPT_OFF_PSC_RST
    |=> wb_dat_o == 32'h0) else $error("unmapped read");
  chk_pin_a_idle: assert property (idle_ok && (!dual || ctrl_a_r[7:6] == 2'h0)
    |-> !compare_out_pin_a_o) else $error("pin a idle");
  chk_pin_b_idle: assert property (idle_ok && (!dual || ctrl_a_r[5:4] == 2'h0)
    |-> !compare_out_pin_b_o) else $error("pin b idle");
  chk_stop_hold: assert property (idle_ok && ctrl_b_r[2:0] == 3'h0
    |=> $stable(compare_out_pin_a_o) && $stable(compare_out_pin_b_o)) else $error("pin moved");
  chk_busy_held: assert property (rd_async && rises_r == 2'h0
    |=> wb_dat_o[`DSPT_SLOT_COUNT]) else $error("busy missing");
  chk_busy_clear: assert property (rd_async && rises_r == 2'h3
    |=> !wb_dat_o[`DSPT_SLOT_COUNT]) else $error("busy stuck");
  chk_wake_gate: assert property (wake_request_o |-> irq_off_r < 6'h20)
    else $error("wake without enable");
  cov_busy_seen: cover property (rd_async && rises_r == 2'h0);
  cov_wake: cover property (wake_request_o);
  cov_pin_b_rise: cover property ($rose(compare_out_pin_b_o));
endmodule
`default_nettype wire

// File: verification/tb_dual_slope_pwm_async_timer.sv
`include "dspt_params.svh"
`default_nettype none
`define CHK(what, exp, got) begin if ((got) !== (exp)) begin \
  $display("Error %s expected %0h seen %0h", what, exp, got); num_errors++; end num_checks++; end
module tb_dual_slope_pwm_async_timer;
  timeunit 1ns;
  timeprecision 1ps;
  import dspt_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  dspt_word_t wb_dat_w = 32'h0;
  dspt_word_t wb_dat_r;
  logic wb_ack, osc, pin_a, pin_b, wake, pad_a;
  logic dir_a = 1'b1; // Port direction of pin a
  int num_errors = 0, num_checks = 0, cycles = 0;
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) cycles <= cycles + 1;
  dspt_timer_top dspt_timer_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'h1),
    .wb_dat_i(wb_dat_w), .wb_ack_o(wb_ack), .wb_dat_o(wb_dat_r), .async_osc_input_i(osc),
    .compare_out_pin_a_o(pin_a), .compare_out_pin_b_o(pin_b), .wake_request_o(wake));
  dspt_osc_model dspt_osc_model_i (.clk_i(clk_i), .run_i(1'b1), .half_i(8'h06),
    .dir_i(dir_a), .pin_a_i(pin_a), .osc_o(osc), .pad_a_o(pad_a));
  task automatic stop_test();
    if (num_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // One classic cycle: hold until ack is sampled high, then release
  task automatic xfer(input logic w, input logic [7:0] a, d, output dspt_word_t q);
    int n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat_w <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 64);
    q = wb_dat_r;
    if (n >= 64) num_errors++;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, d);
    dspt_word_t q;
    xfer(1'b1, a, d, q);
  endtask
  // Rewrite only once no transfer is pending
  task automatic wrb(input logic [7:0] a, d);
    dspt_word_t q;
    int n = 0;
    wr(a, d);
    do begin
      xfer(1'b0, `DSPT_OFF_ASYNC, 8'h00, q);
      n++;
    end while (q[4:0] !== 5'h00 && n < 50);
    if (n >= 50) num_errors++;
  endtask
  task automatic cfg(input logic [7:0] ca, cb, a, b);
    wrb(`DSPT_OFF_CMP_A, a);
    wrb(`DSPT_OFF_CMP_B, b);
    wrb(`DSPT_OFF_CTRL_A, ca);
    wrb(`DSPT_OFF_CTRL_B, cb);
  endtask
  function automatic logic pin(input logic ch);
    return ch ? pin_b : pad_a;
  endfunction
  // Third full period measured, skipping the switch-over transient; a stuck pin hits the watchdog
  task automatic check_pwm(input logic ch, input int hi_exp, lo_exp);
    int hi, lo;
    repeat (2) begin
      hi = 0;
      lo = 0;
      while (pin(ch) !== 1'b0) @(posedge clk_i);
      while (pin(ch) !== 1'b1) @(posedge clk_i);
      while (pin(ch) === 1'b1) begin @(posedge clk_i); hi++; end
      while (pin(ch) === 1'b0) begin @(posedge clk_i); lo++; end
    end
    `CHK("pwm_high", hi_exp, hi);
    `CHK("pwm_low", lo_exp, lo);
  endtask
  task automatic count_high(output int h);
    h = 0;
    repeat (600) @(posedge clk_i);
    repeat (520) begin @(posedge clk_i); h += (pad_a === 1'b1); end
  endtask
  task automatic t_regs();
    dspt_word_t q;
    xfer(1'b0, `DSPT_OFF_ASYNC, 8'h00, q); `CHK("async_reset", 32'h0, q);
    xfer(1'b0, 8'h24, 8'h00, q); `CHK("unmapped", 32'h0, q);
    wrb(`DSPT_OFF_CMP_A, 8'h5a);
    xfer(1'b0, `DSPT_OFF_CMP_A, 8'h00, q); `CHK("cmp_a_back", 32'h5a, q);
  endtask
  task automatic t_sync_pwm();
    for (int com = 2; com <= 3; com++) begin
      cfg(8'((com << 6) | 1), 8'h01, 8'h40, 8'h00);
      check_pwm(1'b0, com == 2 ? 128 : 382, com == 2 ? 382 : 128);
    end
    cfg(8'h21, 8'h09, 8'h80, 8'h20);
    check_pwm(1'b1, 64, 192);
    wr(`DSPT_OFF_PSC_RST, 8'h01);
    cfg(8'h81, 8'h02, 8'h40, 8'h00);
    check_pwm(1'b0, 1024, 3056);
  endtask
  task automatic t_extremes();
    int h;
    cfg(8'h81, 8'h01, 8'h00, 8'h00);
    count_high(h); `CHK("bottom_highs", 0, h);
    dir_a <= 1'b0;
    repeat (2) @(posedge clk_i); `CHK("pad_pulled_up", 1'b1, pad_a);
    dir_a <= 1'b1;
    cfg(8'h81, 8'h01, 8'hff, 8'h00);
    count_high(h); `CHK("max_highs", 520, h);
    cfg(8'h81, 8'h01, 8'h40, 8'h00);
    check_pwm(1'b0, 128, 382);
  endtask
  task automatic wait_wake(input int limit, output logic ok);
    ok = 1'b0;
    repeat (limit) begin @(posedge clk_i); if (wake === 1'b1) ok = 1'b1; end
  endtask
  task automatic t_flags();
    dspt_word_t q;
    logic ok;
    xfer(1'b0, `DSPT_OFF_FLAGS, 8'h00, q); `CHK("ovf_set", 1'b1, q[`DSPT_FLAG_OVF]);
    wrb(`DSPT_OFF_CTRL_B, 8'h00);
    wr(`DSPT_OFF_FLAGS, 8'h07);
    xfer(1'b0, `DSPT_OFF_FLAGS, 8'h00, q); `CHK("flags_clear", 32'h0, q);
    wr(`DSPT_OFF_IRQ_EN, 8'h01);
    wrb(`DSPT_OFF_CTRL_B, 8'h01);
    wait_wake(600, ok); `CHK("wake_sync", 1'b1, ok);
    wr(`DSPT_OFF_IRQ_EN, 8'h00);
  endtask
  // Safe switch: enables off, source, rewrite, wait, clear flags, enable
  task automatic t_async();
    dspt_word_t q;
    logic ok;
    int t0;
    wr(`DSPT_OFF_IRQ_EN, 8'h00);
    wr(`DSPT_OFF_ASYNC, 8'h20);
    t0 = cycles;
    wr(`DSPT_OFF_COUNT, 8'h00);
    xfer(1'b0, `DSPT_OFF_ASYNC, 8'h00, q); `CHK("busy_set", 1'b1, q[2]);
    wrb(`DSPT_OFF_CMP_A, 8'h40);
    `CHK("busy_time", 1'b1, (cycles - t0) >= 12 && (cycles - t0) <= 60);
    wrb(`DSPT_OFF_CTRL_A, 8'h81);
    wrb(`DSPT_OFF_CTRL_B, 8'h01);
    wr(`DSPT_OFF_FLAGS, 8'h07);
    wr(`DSPT_OFF_IRQ_EN, 8'h01);
    check_pwm(1'b0, 1536, 4584);
    wait_wake(6500, ok); `CHK("wake_async", 1'b1, ok);
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_sync_pwm();
    t_extremes();
    t_flags();
    t_async();
    stop_test();
  end
  initial begin
    repeat (90000) @(posedge clk_i);
    num_errors++;
    stop_test();
  end
endmodule
bind dspt_timer_top dspt_timer_checker dspt_timer_checker_i (.*);
`default_nettype wire
